// File: mies_core.sv
// How it works
// - Literal move loads work register, flags kept.
// - Literal move don't-care bits formed as zero.
// - Work register copied to file, flags kept.
// - Literal return loads work, pops into counter.
// - Literal return takes two instruction cycles.
// - Plain return pops stack, two cycles, flags kept.
// - Rotate left through carry, bit 7 out.
// - Destination bit picks work or file; carry only.
// - Sleep clears watchdog counter and prescaler.
// - Sleep clears power-down flag, sets time-out flag.
// - Sleep then halts until wake.
`timescale 1ns/1ns
`default_nettype none

module mies_core
    import mies_pkg::*;
#(
    parameter int WDT_PRE_W = 7,
    parameter int STACK_DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Instruction stream
    input wire logic [MIES_IW-1:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_ack_o,
    output logic [MIES_PCW-1:0] pc_o,
    // Call stack push from the rest of the core
    input wire logic push_i,
    input wire logic [MIES_PCW-1:0] push_addr_i,
    // Wake pin
    input wire logic wake_pin_i,
    // Power state
    output logic osc_run_o,
    output logic wdt_timeout_o,
    // Register port
    input wire logic [MIES_BAW-1:0] reg_addr_i,
    input wire logic [MIES_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [MIES_DW-1:0] reg_rdata_o
);

    mies_state_t state_r;
    logic [MIES_DW-1:0] work_r;
    logic [MIES_PCW-1:0] pc_r;
    logic carry_r, zero_r, ien_r, to_n_r, pwrdn_n_r, run_r;
    logic [MIES_DW-1:0] file_mem [2**MIES_FAW];
    logic [MIES_DW-1:0] wdt_r;
    logic [WDT_PRE_W-1:0] pre_r;
    logic [15:0] tick_cnt_r;
    logic tick;
    logic [MIES_IW-1:0] last_r;
    logic [2:0] wake_sync_r;
    logic wake_sw;
    logic [MIES_DW-1:0] rdata_r;
    logic [MIES_PCW-1:0] stack_top;

    // Decode of the word being taken
    logic take, exec;
    mies_op_t op;
    logic [MIES_FAW-1:0] faddr;
    logic [MIES_DW-1:0] lit, fval, rot;
    logic dest_file;

    assign take = instr_valid_i && run_r && (state_r != MIES_ST_SLEEP);
    assign exec = take && (state_r == MIES_ST_EXEC);
    assign op = mies_decode(instr_i);
    assign faddr = instr_i[MIES_FAW-1:0];
    assign lit = instr_i[MIES_DW-1:0];
    assign dest_file = instr_i[MIES_DEST_BIT];
    assign fval = file_mem[faddr];
    assign rot = {fval[MIES_DW-2:0], carry_r};
    assign instr_ack_o = take;
    assign pc_o = pc_r;
    assign osc_run_o = (state_r != MIES_ST_SLEEP);
    assign reg_rdata_o = rdata_r;

    logic exec_pop;
    assign exec_pop = exec && (op == MIES_OP_RETURN || op == MIES_OP_LITRET || op == MIES_OP_IRET);

    mies_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(MIES_PCW)
    ) u_stack (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .push_i(push_i),
        .push_data_i(push_addr_i),
        .pop_i(exec_pop),
        .top_o(stack_top)
    );

    // Wake pin: three flops, change counts once the last two agree
    logic wake_pin_lvl_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wake_sync_r <= 3'h0;
            wake_pin_lvl_r <= 1'b0;
        end
        else
        begin
            wake_sync_r <= {wake_sync_r[1:0], wake_pin_i};
            if (wake_sync_r[1] == wake_sync_r[2])
                wake_pin_lvl_r <= wake_sync_r[2];
        end
    end

    assign wake_sw = reg_wr_i && reg_addr_i == MIES_REG_CTRL && reg_wdata_i[MIES_CTRL_WAKE];

    // Sequencer: returns spend a second cycle discarding the prefetched word
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_r <= MIES_ST_EXEC;
        else
        begin
            unique case (state_r)
                MIES_ST_EXEC:
                begin
                    if (exec_pop)
                        state_r <= MIES_ST_FLUSH;
                    else if (exec && op == MIES_OP_SLEEP)
                        state_r <= MIES_ST_SLEEP;
                end
                MIES_ST_FLUSH:
                begin
                    if (take)
                        state_r <= MIES_ST_EXEC;
                end
                MIES_ST_SLEEP:
                begin
                    if (wake_pin_lvl_r || wake_sw || wdt_timeout_o)
                        state_r <= MIES_ST_EXEC;
                end
                default:
                    state_r <= MIES_ST_EXEC;
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pc_r <= MIES_PC_RST;
        else if (exec_pop)
            pc_r <= stack_top;
        else if (take)
            pc_r <= pc_r + MIES_PC_ONE;
    end

    // Work register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            work_r <= MIES_BYTE_ZERO;
        else if (reg_wr_i && reg_addr_i == MIES_REG_WORK)
            work_r <= reg_wdata_i;
        else if (exec && (op == MIES_OP_LITW || op == MIES_OP_LITRET))
            work_r <= lit;
        else if (exec && op == MIES_OP_ROTL && !dest_file)
            work_r <= rot;
    end

    // File registers; the core's own write wins over the port
    always_ff @(posedge clk_sys_i)
    begin
        if (reg_wr_i && reg_addr_i[MIES_FILE_SEL])
            file_mem[reg_addr_i[MIES_FAW-1:0]] <= reg_wdata_i;
        if (exec && op == MIES_OP_TOFILE)
            file_mem[faddr] <= work_r;
        else if (exec && op == MIES_OP_ROTL && dest_file)
            file_mem[faddr] <= rot;
    end

    // Status flags; besides a bus write only rotate touches carry; sleep and a watchdog time-out touch the power flags
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            carry_r <= 1'b0;
            zero_r <= 1'b0;
            ien_r <= 1'b0;
            to_n_r <= 1'b1;
            pwrdn_n_r <= 1'b1;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == MIES_REG_STAT)
            begin
                carry_r <= reg_wdata_i[MIES_ST_C];
                zero_r <= reg_wdata_i[MIES_ST_Z];
                ien_r <= reg_wdata_i[MIES_ST_IEN];
            end
            if (exec && op == MIES_OP_ROTL)
                carry_r <= fval[MIES_DW-1];
            if (exec && op == MIES_OP_IRET)
                ien_r <= 1'b1;
            if (exec && op == MIES_OP_SLEEP)
            begin
                pwrdn_n_r <= 1'b0;
                to_n_r <= 1'b1;
            end
            else if (wdt_timeout_o)
                to_n_r <= 1'b0;
        end
    end

    // Run enable from software
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            run_r <= 1'b0;
        else if (reg_wr_i && reg_addr_i == MIES_REG_CTRL)
            run_r <= reg_wdata_i[MIES_CTRL_RUN];
    end

    // Last executed word; literal don't-cares forced to zero
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            last_r <= '0;
        else if (exec && (op == MIES_OP_LITW || op == MIES_OP_LITRET))
            last_r <= instr_i & ~MIES_LIT_DC;
        else if (exec)
            last_r <= instr_i;
    end

    // Watchdog base tick divider, one-cycle enable
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
    assign tick = (tick_cnt_r == 16'(MIES_WDT_TICK_CYC - 1));

    // Watchdog keeps counting in sleep; it is the documented way out
    logic wdt_wrap;
    assign wdt_wrap = tick && (&pre_r) && (&wdt_r);
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pre_r <= '0;
            wdt_r <= MIES_BYTE_ZERO;
            wdt_timeout_o <= 1'b0;
        end
        else
        begin
            wdt_timeout_o <= wdt_wrap;
            if (exec && op == MIES_OP_SLEEP)
            begin
                pre_r <= '0;
                wdt_r <= MIES_BYTE_ZERO;
            end
            else if (tick)
            begin
                pre_r <= pre_r + 1'b1;
                if (&pre_r)
                    wdt_r <= wdt_r + 8'h01;
            end
        end
    end

    // Register read, data one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_r <= MIES_BYTE_ZERO;
        else if (reg_rd_i)
        begin
            if (reg_addr_i[MIES_FILE_SEL])
                rdata_r <= file_mem[reg_addr_i[MIES_FAW-1:0]];
            else
            begin
                unique case (reg_addr_i)
                    MIES_REG_CTRL: rdata_r <= {7'h00, run_r};
                    MIES_REG_STAT: rdata_r <= {2'h0, state_r == MIES_ST_SLEEP, ien_r, to_n_r, pwrdn_n_r, zero_r, carry_r};
                    MIES_REG_WORK: rdata_r <= work_r;
                    MIES_REG_PCLO: rdata_r <= pc_r[7:0];
                    MIES_REG_PCHI: rdata_r <= {3'h0, pc_r[MIES_PCW-1:8]};
                    MIES_REG_WDOG: rdata_r <= wdt_r;
                    MIES_REG_LASTLO: rdata_r <= last_r[7:0];
                    MIES_REG_LASTHI: rdata_r <= {2'h0, last_r[MIES_IW-1:8]};
                    default: rdata_r <= MIES_BYTE_ZERO;
                endcase
            end
        end
    end

    // Checks; bus writes are excluded where they could mask the effect
    logic quiet;
    assign quiet = !reg_wr_i;

    property p_litw;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_LITW && quiet |=> work_r == $past(lit) && $stable(carry_r) && $stable(pwrdn_n_r);
    endproperty
    a_litw: assert property (p_litw) else $error("literal move wrong");

    property p_dc_zero;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_LITW |=> (last_r & MIES_LIT_DC) == 14'h0000;
    endproperty
    a_dc_zero: assert property (p_dc_zero) else $error("don't-care bits kept");

    property p_tofile;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_TOFILE && quiet |=> file_mem[$past(faddr)] == $past(work_r) && $stable(carry_r);
    endproperty
    a_tofile: assert property (p_tofile) else $error("work to file wrong");

    property p_litret;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_LITRET && quiet |=> pc_r == $past(stack_top) && work_r == $past(lit);
    endproperty
    a_litret: assert property (p_litret) else $error("literal return wrong");

    property p_two_cycle;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec_pop ##1 take |=> state_r == MIES_ST_EXEC && pc_r == $past(pc_r, 1) + MIES_PC_ONE;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("return not two cycles");

    property p_return;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_RETURN && quiet |=> pc_r == $past(stack_top) && state_r == MIES_ST_FLUSH && $stable(carry_r);
    endproperty
    a_return: assert property (p_return) else $error("return wrong");

    property p_rotl;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_ROTL && !dest_file && quiet |=> carry_r == $past(fval[7]) && work_r == $past(rot);
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate wrong");

    property p_sleep;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_SLEEP |=> wdt_r == 8'h00 && !pwrdn_n_r && to_n_r && !osc_run_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

    property p_iret;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_IRET && quiet |=> ien_r && pc_r == $past(stack_top);
    endproperty
    a_iret: assert property (p_iret) else $error("interrupt return wrong");

    property p_nop;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        exec && op == MIES_OP_NOP && quiet |=> pc_r == $past(pc_r) + MIES_PC_ONE && $stable(work_r) && $stable(carry_r);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    c_litret: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) exec && op == MIES_OP_LITRET);
    c_rotl_file: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) exec && op == MIES_OP_ROTL && dest_file);
    c_wake: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) state_r == MIES_ST_SLEEP ##1 osc_run_o);

endmodule
`default_nettype wire

// File: mies_core_bench.sv
`timescale 1ns/1ns
`default_nettype none

module mies_core_bench
    import mies_pkg::*;
;
    // Stimulus and observed signals
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [MIES_IW-1:0] instr_i = '0;
    logic instr_valid_i = 1'b0;
    logic instr_ack_o;
    logic [MIES_PCW-1:0] pc_o;
    logic push_i = 1'b0;
    logic [MIES_PCW-1:0] push_addr_i = '0;
    logic wake_pin_i = 1'b0;
    logic osc_run_o;
    logic wdt_timeout_o;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    int fail_count = 0;
    int checks = 0;
    int seed = 49;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    string name_q[$];
    logic [7:0] w_m;
    logic [7:0] st_m;

    // Short prescaler so a watchdog wrap fits in the run
    mies_core #(.WDT_PRE_W(1), .STACK_DEPTH(8)) mies_core_i (
        .clk_sys_i, .nrst_i, .instr_i, .instr_valid_i, .instr_ack_o, .pc_o,
        .push_i, .push_addr_i, .wake_pin_i, .osc_run_o, .wdt_timeout_o,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o
    );

    // 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timed_out(input string name);
        fail_count++;
        $display("ERROR %s expected done seen timeout", name);
        complete_run();
    endtask

    // Bus tasks drop the instruction valid so no word slips in
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        instr_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        instr_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic idle();
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        instr_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // Offer one word and hold it until the core takes it
    task automatic exec(input logic [13:0] w);
        int n;
        n = 0;
        instr_i <= w;
        instr_valid_i <= 1'b1;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (instr_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            timed_out("instr_ack");
    endtask

    task automatic wait_osc(input int bound);
        int n;
        n = 0;
        while (osc_run_o !== 1'b1 && n < bound)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= bound)
            timed_out("osc_run");
    endtask

    // Read data is checked in the cycle after the strobe
    always @(posedge clk_sys_i)
        rd_pend <= reg_rd_i;

    always @(negedge clk_sys_i)
        if (rd_pend && exp_q.size() > 0)
            check(name_q.pop_front(), reg_rdata_o, exp_q.pop_front());

    initial
    begin
        logic [7:0] k;
        logic [7:0] v;
        logic [6:0] f;
        logic [12:0] a;
        logic [13:0] ops [3];
        int n;
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        // Reset state, unmapped place, flags preset
        check("pc", pc_o, 16'h0000);
        check("osc_run", osc_run_o, 16'h0001);
        st_m = 8'h0c;
        w_m = 8'h00;
        rd(MIES_REG_STAT, st_m, "stat");
        rd(MIES_REG_WORK, w_m, "work");
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00, "unmapped");
        wr(MIES_REG_STAT, 8'h03);
        wr(MIES_REG_CTRL, 8'h01);
        st_m = 8'h0f;
        // Literal moves, boundary values and random don't-care bits
        for (int i = 0; i < 4; i++)
        begin
            k = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            exec(MIES_LITW_VAL | 14'(k) | (14'($random(seed)) & MIES_LIT_DC));
            w_m = k;
            rd(MIES_REG_WORK, w_m, "work");
            rd(MIES_REG_STAT, st_m, "stat");
            rd(MIES_REG_LASTHI, 8'h30, "last_hi");
            rd(MIES_REG_LASTLO, k, "last_lo");
        end
        // Work to file at both ends of the address range
        for (int i = 0; i < 3; i++)
        begin
            f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'h40;
            exec(MIES_TOFILE_VAL | 14'(f));
            rd({1'b1, f}, w_m, "file");
        end
        rd(MIES_REG_STAT, st_m, "stat");
        // Rotate with both destinations; carry flips each way
        for (int d = 0; d < 2; d++)
        begin
            f = 7'h20 + 7'(d);
            v = {d[0], 7'($random(seed))};
            wr({1'b1, f}, v);
            exec(MIES_ROTL_VAL | 14'(d << MIES_DEST_BIT) | 14'(f));
            k = {v[6:0], st_m[0]};
            st_m[0] = v[7];
            if (d == 0)
                w_m = k;
            rd(MIES_REG_WORK, w_m, "work");
            rd({1'b1, f}, (d == 0) ? v : k, "file");
            rd(MIES_REG_STAT, st_m, "stat");
        end
        // No-operation with its don't-care bits set
        #1;
        a = pc_o;
        exec(MIES_NOP_VAL | 14'h0060);
        #1;
        check("pc", pc_o, 16'(a + 13'h1));
        rd(MIES_REG_WORK, w_m, "work");
        rd(MIES_REG_STAT, st_m, "stat");
        // Returns; the word after each must be discarded
        ops[0] = MIES_RETURN_VAL;
        ops[1] = MIES_IRET_VAL;
        ops[2] = MIES_LITRET_VAL | 14'h00a5;
        for (int i = 0; i < 3; i++)
        begin
            a = 13'($random(seed));
            push_addr_i <= a;
            push_i <= 1'b1;
            reg_rd_i <= 1'b0;
            @(posedge clk_sys_i);
            push_i <= 1'b0;
            exec(ops[i]);
            #1;
            check("pc", pc_o, 16'(a));
            exec(MIES_LITW_VAL | 14'h005a);
            #1;
            check("pc", pc_o, 16'(a + 13'h1));
            if (i == 1)
                st_m[4] = 1'b1;
            if (i == 2)
                w_m = 8'ha5;
            rd(MIES_REG_WORK, w_m, "work");
            rd(MIES_REG_STAT, st_m, "stat");
        end
        // Let the watchdog count before sleeping
        idle();
        repeat (450) @(posedge clk_sys_i);
        exec(MIES_SLEEP_VAL);
        #1;
        check("osc_run", osc_run_o, 16'h0000);
        st_m[2] = 1'b0;
        st_m[3] = 1'b1;
        st_m[5] = 1'b1;
        rd(MIES_REG_WDOG, 8'h00, "watchdog");
        rd(MIES_REG_STAT, st_m, "stat");
        wr(MIES_REG_CTRL, 8'h03);
        idle();
        wait_osc(20);
        // Sleep again, wake through the pin
        exec(MIES_SLEEP_VAL);
        idle();
        wake_pin_i <= 1'b1;
        @(posedge clk_sys_i);
        wait_osc(20);
        wake_pin_i <= 1'b0;
        // Let the synchronised pin level fall, or the next sleep wakes at once
        repeat (6) @(posedge clk_sys_i);
        // A cleared watchdog needs a full wrap, 256 counts of 200 cycles
        exec(MIES_SLEEP_VAL);
        idle();
        #1;
        check("osc_run", osc_run_o, 16'h0000);
        n = 0;
        while (wdt_timeout_o !== 1'b1 && n < 60000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 60000)
            timed_out("wdt_timeout");
        check("wdt_wrap_late", 16'(n >= 51000), 16'h0001);
        wait_osc(10);
        idle();
        idle();
        complete_run();
    end
endmodule

`default_nettype wire

// File: mies_pkg.sv
`default_nettype none

package mies_pkg;

    // Widths of the datapath
    localparam int MIES_IW = 14;
    localparam int MIES_PCW = 13;
    localparam int MIES_DW = 8;
    localparam int MIES_FAW = 7;
    localparam int MIES_BAW = 8;

    // Instruction patterns and the bits each one compares
    localparam logic [13:0] MIES_NOP_VAL = 14'h0000;
    localparam logic [13:0] MIES_NOP_MSK = 14'h3f9f;
    localparam logic [13:0] MIES_TOFILE_VAL = 14'h0080;
    localparam logic [13:0] MIES_TOFILE_MSK = 14'h3f80;
    localparam logic [13:0] MIES_RETURN_VAL = 14'h0008;
    localparam logic [13:0] MIES_IRET_VAL = 14'h0009;
    localparam logic [13:0] MIES_SLEEP_VAL = 14'h0063;
    localparam logic [13:0] MIES_FULL_MSK = 14'h3fff;
    localparam logic [13:0] MIES_ROTL_VAL = 14'h0d00;
    localparam logic [13:0] MIES_ROTL_MSK = 14'h3f00;
    localparam logic [13:0] MIES_LITW_VAL = 14'h3000;
    localparam logic [13:0] MIES_LITRET_VAL = 14'h3400;
    localparam logic [13:0] MIES_LIT_MSK = 14'h3c00;
    localparam logic [13:0] MIES_LIT_DC = 14'h0300;
    localparam int MIES_DEST_BIT = 7;

    // Register offsets; bit 7 of the address selects the file window
    localparam logic [7:0] MIES_REG_CTRL = 8'h00;
    localparam logic [7:0] MIES_REG_STAT = 8'h01;
    localparam logic [7:0] MIES_REG_WORK = 8'h02;
    localparam logic [7:0] MIES_REG_PCLO = 8'h03;
    localparam logic [7:0] MIES_REG_PCHI = 8'h04;
    localparam logic [7:0] MIES_REG_WDOG = 8'h05;
    localparam logic [7:0] MIES_REG_LASTLO = 8'h06;
    localparam logic [7:0] MIES_REG_LASTHI = 8'h07;
    localparam int MIES_FILE_SEL = 7;

    // Control and status bit positions
    localparam int MIES_CTRL_RUN = 0;
    localparam int MIES_CTRL_WAKE = 1;
    localparam int MIES_ST_C = 0;
    localparam int MIES_ST_Z = 1;
    localparam int MIES_ST_PDN = 2;
    localparam int MIES_ST_TO = 3;
    localparam int MIES_ST_IEN = 4;
    localparam int MIES_ST_SLP = 5;

    // Reset values and the counter step
    localparam logic [12:0] MIES_PC_RST = 13'h0000;
    localparam logic [7:0] MIES_BYTE_ZERO = 8'h00;
    localparam logic [12:0] MIES_PC_ONE = 13'h0001;

    // Watchdog base tick
    localparam int MIES_CLK_NS = 10;
    localparam int MIES_WDT_TICK_NS = 1000;
    localparam int MIES_WDT_TICK_CYC = (MIES_WDT_TICK_NS + MIES_CLK_NS - 1) / MIES_CLK_NS;

    typedef enum logic [1:0] {
        MIES_ST_EXEC = 2'b00,
        MIES_ST_FLUSH = 2'b01,
        MIES_ST_SLEEP = 2'b10
    } mies_state_t;

    typedef enum logic [3:0] {
        MIES_OP_OTHER = 4'h0,
        MIES_OP_NOP = 4'h1,
        MIES_OP_LITW = 4'h2,
        MIES_OP_TOFILE = 4'h3,
        MIES_OP_LITRET = 4'h4,
        MIES_OP_RETURN = 4'h5,
        MIES_OP_IRET = 4'h6,
        MIES_OP_ROTL = 4'h7,
        MIES_OP_SLEEP = 4'h8
    } mies_op_t;

    // Pattern match of one instruction word
    function automatic logic mies_match(input logic [13:0] iw, input logic [13:0] val, input logic [13:0] msk);
        return (iw & msk) == val;
    endfunction

    function automatic mies_op_t mies_decode(input logic [13:0] iw);
        mies_op_t op;
        op = MIES_OP_OTHER;
        if (mies_match(iw, MIES_NOP_VAL, MIES_NOP_MSK))
            op = MIES_OP_NOP;
        else if (mies_match(iw, MIES_TOFILE_VAL, MIES_TOFILE_MSK))
            op = MIES_OP_TOFILE;
        else if (mies_match(iw, MIES_RETURN_VAL, MIES_FULL_MSK))
            op = MIES_OP_RETURN;
        else if (mies_match(iw, MIES_IRET_VAL, MIES_FULL_MSK))
            op = MIES_OP_IRET;
        else if (mies_match(iw, MIES_SLEEP_VAL, MIES_FULL_MSK))
            op = MIES_OP_SLEEP;
        else if (mies_match(iw, MIES_ROTL_VAL, MIES_ROTL_MSK))
            op = MIES_OP_ROTL;
        else if (mies_match(iw, MIES_LITW_VAL, MIES_LIT_MSK))
            op = MIES_OP_LITW;
        else if (mies_match(iw, MIES_LITRET_VAL, MIES_LIT_MSK))
            op = MIES_OP_LITRET;
        return op;
    endfunction

endpackage

`default_nettype wire

// File: mies_stack.sv
`timescale 1ns/1ns
`default_nettype none

module mies_stack
    import mies_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = MIES_PCW
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Push and pop
    input wire logic push_i,
    input wire logic [AW-1:0] push_data_i,
    input wire logic pop_i,
    // Current top entry
    output logic [AW-1:0] top_o
);
    localparam int PW = $clog2(DEPTH);

    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] ptr_r;

    // Circular stack: overflow silently wraps, like a hardware return stack
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ptr_r <= '0;
        else if (push_i && !pop_i)
            ptr_r <= ptr_r + 1'b1;
        else if (pop_i && !push_i)
            ptr_r <= ptr_r - 1'b1;
    end

    // Entries carry no reset; only the pointer matters
    always_ff @(posedge clk_sys_i)
    begin
        if (push_i && !pop_i)
            mem[ptr_r] <= push_data_i;
    end

    assign top_o = mem[ptr_r - 1'b1];

endmodule
`default_nettype wire
